// ===== design/tle_pkg.sv
// constants, loop modes and timing figures shared by the test loop engine
// assumes a single 40 MHz clock and tti tick pulses from the modem timing
//
// Overview of operation
// - block loopback copies block and crc uplink
// - variable rate picks smallest fitting uplink format
// - nothing fits: truncate to largest uplink format
// - counting close clears the sdu counter
// - counter adds one per good multicast sdu
// - counter is 32 bits, wrap undefined
// - ip loopback feeds convergence output to filter input
// - loopback delay constant while configuration unchanged
// - delay at most ten times the tti
// - sdu loopback bound needs transparent, unsegmented bearer
// - sdu loopback bound skips unacknowledged high speed bearers
// - block loopback always bounded, counting never bounded
// - sdu loopback returns at least four sdus per tti
// - open ignored without bidirectional bearer
// - open clears all loops then replies complete
// - open replies even when already open
// - two low mode bits select the loop mode
package tle_pkg;

	// loop mode codes, loop_mode_bit_high then loop_mode_bit_low
	localparam logic [1:0] TLE_MODE_SDU = 2'h0;
	localparam logic [1:0] TLE_MODE_TB = 2'h1;
	localparam logic [1:0] TLE_MODE_COUNT = 2'h2;
	localparam logic [1:0] TLE_MODE_IP = 2'h3;

	// widths of the block length fields and the sdu counter
	localparam int TLE_TB_BITS_W = 16;
	localparam int TLE_NEED_W = 17;
	localparam int TLE_CNT_W = 32;
	localparam logic [TLE_CNT_W-1:0] TLE_CNT_RESET = 32'h0;

	// loopback delay: uplink leaves on the tti boundary after the block ends
	localparam int TLE_LOOP_DELAY_TTI = 1;
	localparam int TLE_MAX_DELAY_TTI_MULT = 10;
	localparam int TLE_MIN_SDU_PER_TTI = 4;

	// controller guard time and clock rate, kept for reference only
	localparam int TLE_GUARD_MS = 2500;
	localparam int TLE_CLK_HZ = 40000000;

endpackage

// ===== design/tle_sel_if.sv
// carries the uplink format query between the engine and its format selector
// assumes combinational answer within the same cycle
`timescale 1ns/1ps
interface tle_sel_if #(
	parameter int NUM_TF = 4
);
	logic [tle_pkg::TLE_NEED_W-1:0] need_bits;
	logic [tle_pkg::TLE_TB_BITS_W-1:0] tf_size [NUM_TF];
	logic [$clog2(NUM_TF+1)-1:0] tf_idx;
	logic [tle_pkg::TLE_TB_BITS_W-1:0] tf_bits;
	logic truncated;

	modport req (output need_bits, output tf_size, input tf_idx, input tf_bits, input truncated);
	modport sel (input need_bits, input tf_size, output tf_idx, output tf_bits, output truncated);
endinterface

// ===== design/tle_tf_select.sv
// picks the uplink transport format for a looped block
// assumes the format table is stable while a block is being sent
`timescale 1ns/1ps
module tle_tf_select #(
	parameter int NUM_TF = 4
) (
	tle_sel_if.sel sel
);
	import tle_pkg::*;

	logic [NUM_TF-1:0] fits;
	logic [TLE_TB_BITS_W-1:0] best_sz;
	logic [TLE_TB_BITS_W-1:0] big_sz;
	logic [$clog2(NUM_TF+1)-1:0] best_idx;
	logic [$clog2(NUM_TF+1)-1:0] big_idx;
	logic any_fit;

	// per-format fit flags
	genvar g;
	generate
		for (g = 0; g < NUM_TF; g++) begin : g_fit
			assign fits[g] = {1'b0, sel.tf_size[g]} >= sel.need_bits;
		end
	endgenerate

	// smallest fitting and largest formats
	always_comb begin
		best_sz = '1;
		big_sz = '0;
		best_idx = '0;
		big_idx = '0;
		any_fit = 1'b0;
		for (int i = 0; i < NUM_TF; i++) begin
			if (fits[i] && (!any_fit || sel.tf_size[i] < best_sz)) begin
				best_sz = sel.tf_size[i];
				best_idx = i[$clog2(NUM_TF+1)-1:0];
				any_fit = 1'b1;
			end
			if (sel.tf_size[i] > big_sz) begin
				big_sz = sel.tf_size[i];
				big_idx = i[$clog2(NUM_TF+1)-1:0];
			end
		end
	end

	// fall back to the largest format and truncate
	assign sel.tf_idx = any_fit ? best_idx : big_idx;
	assign sel.tf_bits = any_fit ? best_sz : big_sz;
	assign sel.truncated = !any_fit;
endmodule // tle_tf_select

// ===== design/tle_loop_engine.sv
// terminal test loop engine: loop commands, block loopback, sdu/ip loopback, sdu counting
// assumes commands arrive decoded as one-cycle pulses and tti_tick_i marks tti boundaries
`timescale 1ns/1ps
module tle_loop_engine #(
	parameter int NUM_RB = 8,
	parameter int DATA_W = 32,
	parameter int DEPTH = 2048,
	parameter int NUM_TF = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// loop commands
	input wire logic close_cmd_i,
	input wire logic [1:0] close_mode_i,
	input wire logic open_cmd_i,
	input wire logic test_mode_active_i,
	input wire logic [NUM_RB-1:0] bidir_rb_i,
	input wire logic [NUM_RB-1:0] rb_release_i,
	input wire logic mtch_ready_i,
	output logic close_done_o,
	output logic open_done_o,
	output logic [NUM_RB-1:0] loop_closed_o,
	output logic [1:0] loop_mode_o,
	// bearer properties for the delay bound
	input wire logic rb_transparent_i,
	input wire logic rb_unsegmented_i,
	input wire logic rb_um_high_speed_i,
	input wire logic cfg_change_i,
	output logic delay_bound_o,
	output logic delay_fixed_o,
	// timing
	input wire logic tti_tick_i,
	// downlink transport block with crc
	input wire logic dl_valid_i,
	input wire logic [DATA_W-1:0] dl_data_i,
	input wire logic dl_last_i,
	input wire logic [$clog2(NUM_RB)-1:0] dl_rb_i,
	input wire logic [tle_pkg::TLE_TB_BITS_W-1:0] dl_tb_bits_i,
	input wire logic [tle_pkg::TLE_TB_BITS_W-1:0] dl_crc_bits_i,
	output logic dl_ready_o,
	// uplink format table
	input wire logic [tle_pkg::TLE_TB_BITS_W-1:0] ul_tf_size_i [NUM_TF],
	// uplink transport block
	output logic ul_valid_o,
	output logic [DATA_W-1:0] ul_data_o,
	output logic ul_last_o,
	output logic [$clog2(NUM_RB)-1:0] ul_rb_o,
	output logic [$clog2(NUM_TF+1)-1:0] ul_tf_idx_o,
	output logic [tle_pkg::TLE_TB_BITS_W-1:0] ul_bits_o,
	output logic ul_truncated_o,
	input wire logic ul_ready_i,
	// downlink sdu / ip pdu stream
	input wire logic sdu_valid_i,
	input wire logic [DATA_W-1:0] sdu_data_i,
	input wire logic sdu_last_i,
	input wire logic [$clog2(NUM_RB)-1:0] sdu_rb_i,
	output logic sdu_ready_o,
	// looped sdu toward rlc sap or toward the uplink filter
	output logic up_valid_o,
	output logic [DATA_W-1:0] up_data_o,
	output logic up_last_o,
	output logic [$clog2(NUM_RB)-1:0] up_rb_o,
	output logic up_to_filter_o,
	input wire logic up_ready_i,
	// multicast sdu counting
	input wire logic mtch_sdu_ok_i,
	output logic [tle_pkg::TLE_CNT_W-1:0] sdu_count_o
);
	import tle_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [TLE_NEED_W-1:0] WORD_BITS = TLE_NEED_W'(DATA_W);
	localparam logic [TLE_NEED_W-1:0] DEPTH_WORDS = TLE_NEED_W'(DEPTH);

	typedef enum logic [1:0] {
		TLE_ST_RX,
		TLE_ST_HOLD,
		TLE_ST_SEND
	} tle_state_t;

	// command state
	logic [NUM_RB-1:0] closed_q;
	logic [1:0] mode_q;
	logic counting_q;
	logic close_ok;
	logic open_ok;
	logic close_done_q;
	logic open_done_q;

	// counter
	logic [TLE_CNT_W-1:0] count_q;

	// block path
	tle_state_t state_q;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [TLE_NEED_W-1:0] wr_cnt_q;
	logic [TLE_NEED_W-1:0] src_words_q;
	logic [TLE_NEED_W-1:0] need_q;
	logic [TLE_NEED_W-1:0] tx_idx_q;
	logic [TLE_NEED_W-1:0] tx_total;
	logic [TLE_NEED_W-1:0] len_bits;
	logic [TLE_NEED_W-1:0] rem_bits;
	logic [$clog2(NUM_RB)-1:0] blk_rb_q;
	logic blk_keep_q;
	logic dl_take;
	logic tb_closed;
	logic ul_adv;
	logic ul_valid_q;
	logic [DATA_W-1:0] ul_data_q;
	logic ul_last_q;
	logic [DATA_W-1:0] word_src;

	// sdu path
	logic up_valid_q;
	logic [DATA_W-1:0] up_data_q;
	logic up_last_q;
	logic [$clog2(NUM_RB)-1:0] up_rb_q;
	logic up_filter_q;
	logic sdu_loop;
	logic up_free;

	// delay tracking
	logic fixed_q;

	// format selection
	tle_sel_if #(.NUM_TF(NUM_TF)) sel_bus ();

	tle_tf_select #(.NUM_TF(NUM_TF)) u_sel (
		.sel(sel_bus.sel)
	);

	// feed the selector with the stored block length and format table
	assign sel_bus.need_bits = need_q;
	always_comb begin
		for (int i = 0; i < NUM_TF; i++) begin
			sel_bus.tf_size[i] = ul_tf_size_i[i];
		end
	end

	// command acceptance
	assign close_ok = close_cmd_i && test_mode_active_i
		&& ((close_mode_i == TLE_MODE_COUNT) ? mtch_ready_i : (|bidir_rb_i));
	assign open_ok = open_cmd_i && (|bidir_rb_i);

	// per-bearer loop state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			closed_q <= '0;
		end else if (!test_mode_active_i || open_ok) begin
			closed_q <= '0;
		end else if (close_ok && close_mode_i != TLE_MODE_COUNT) begin
			closed_q <= bidir_rb_i & ~rb_release_i;
		end else begin
			closed_q <= closed_q & ~rb_release_i;
		end
	end

	// selected mode and counting state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mode_q <= TLE_MODE_SDU;
			counting_q <= 1'b0;
		end else if (!test_mode_active_i || open_ok) begin
			counting_q <= 1'b0;
		end else if (close_ok) begin
			mode_q <= close_mode_i;
			counting_q <= (close_mode_i == TLE_MODE_COUNT);
		end
	end

	// completion replies, one-cycle pulses the cycle after the command
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			close_done_q <= 1'b0;
			open_done_q <= 1'b0;
		end else begin
			close_done_q <= close_ok;
			open_done_q <= open_ok;
		end
	end

	assign close_done_o = close_done_q;
	assign open_done_o = open_done_q;
	assign loop_closed_o = closed_q;
	assign loop_mode_o = mode_q;

	// multicast sdu counter, cleared by the counting close
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			count_q <= TLE_CNT_RESET;
		end else if (close_ok && close_mode_i == TLE_MODE_COUNT) begin
			count_q <= TLE_CNT_RESET;
		end else if (counting_q && mtch_sdu_ok_i) begin
			count_q <= count_q + 32'h1;
		end
	end

	assign sdu_count_o = count_q;

	// delay bound applies per mode and bearer kind
	always_comb begin
		case (mode_q)
			TLE_MODE_SDU: delay_bound_o = rb_transparent_i && rb_unsegmented_i && !rb_um_high_speed_i;
			TLE_MODE_TB: delay_bound_o = 1'b1;
			TLE_MODE_COUNT: delay_bound_o = 1'b0;
			default: delay_bound_o = 1'b1;
		endcase
	end

	// delay stays fixed until the loop set or bearer configuration changes
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fixed_q <= 1'b0;
		end else if (cfg_change_i || close_ok || open_ok || |rb_release_i) begin
			fixed_q <= 1'b0;
		end else begin
			fixed_q <= |closed_q;
		end
	end

	assign delay_fixed_o = fixed_q;

	// block loopback path: collect, hold to tti boundary, send
	assign tb_closed = mode_q == TLE_MODE_TB && closed_q[dl_rb_i];
	assign dl_ready_o = state_q == TLE_ST_RX;
	assign dl_take = dl_valid_i && state_q == TLE_ST_RX;

	// uplink length: format size when it fits (pad), else truncated
	assign len_bits = {1'b0, sel_bus.tf_bits};
	assign tx_total = (len_bits + WORD_BITS - 17'h1) / WORD_BITS;
	assign rem_bits = len_bits % WORD_BITS;
	assign ul_adv = !ul_valid_q || ul_ready_i;

	// source word, zero beyond the stored block, last word masked to length
	always_comb begin
		word_src = (tx_idx_q < src_words_q) ? mem[tx_idx_q[AW-1:0]] : '0;
		if (tx_idx_q == tx_total - 17'h1 && rem_bits != '0) begin
			for (int b = 0; b < DATA_W; b++) begin
				if (TLE_NEED_W'(b) >= rem_bits) begin
					word_src[b] = 1'b0;
				end
			end
		end
	end

	// buffer write
	always_ff @(posedge sys_clk_i) begin
		if (dl_take && wr_cnt_q < DEPTH_WORDS) begin
			mem[wr_cnt_q[AW-1:0]] <= dl_data_i;
		end
	end

	// block sequencing
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_q <= TLE_ST_RX;
			wr_cnt_q <= '0;
			src_words_q <= '0;
			need_q <= '0;
			blk_rb_q <= '0;
			blk_keep_q <= 1'b0;
			tx_idx_q <= '0;
		end else begin
			case (state_q)
				TLE_ST_RX: begin
					if (dl_take) begin
						wr_cnt_q <= (wr_cnt_q < DEPTH_WORDS) ? wr_cnt_q + 17'h1 : wr_cnt_q;
						if (dl_last_i) begin
							src_words_q <= (wr_cnt_q < DEPTH_WORDS) ? wr_cnt_q + 17'h1 : wr_cnt_q;
							need_q <= {1'b0, dl_tb_bits_i} + {1'b0, dl_crc_bits_i};
							blk_rb_q <= dl_rb_i;
							blk_keep_q <= tb_closed;
							wr_cnt_q <= '0;
							state_q <= TLE_ST_HOLD;
						end
					end
				end
				TLE_ST_HOLD: begin
					tx_idx_q <= '0;
					if (!blk_keep_q) begin
						state_q <= TLE_ST_RX;
					end else if (tti_tick_i) begin
						state_q <= TLE_ST_SEND;
					end
				end
				TLE_ST_SEND: begin
					if (ul_adv) begin
						if (tx_idx_q < tx_total) begin
							tx_idx_q <= tx_idx_q + 17'h1;
						end else begin
							state_q <= TLE_ST_RX;
						end
					end
				end
				default: state_q <= TLE_ST_RX;
			endcase
		end
	end

	// uplink output register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ul_valid_q <= 1'b0;
			ul_data_q <= '0;
			ul_last_q <= 1'b0;
		end else if (ul_adv) begin
			if (state_q == TLE_ST_SEND && tx_idx_q < tx_total) begin
				ul_valid_q <= 1'b1;
				ul_data_q <= word_src;
				ul_last_q <= tx_idx_q == tx_total - 17'h1;
			end else begin
				ul_valid_q <= 1'b0;
				ul_last_q <= 1'b0;
			end
		end
	end

	// format fields held for the whole block
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ul_tf_idx_o <= '0;
			ul_bits_o <= '0;
			ul_truncated_o <= 1'b0;
			ul_rb_o <= '0;
		end else if (state_q == TLE_ST_HOLD) begin
			ul_tf_idx_o <= sel_bus.tf_idx;
			ul_bits_o <= sel_bus.tf_bits;
			ul_truncated_o <= sel_bus.truncated;
			ul_rb_o <= blk_rb_q;
		end
	end

	assign ul_valid_o = ul_valid_q;
	assign ul_data_o = ul_data_q;
	assign ul_last_o = ul_last_q;

	// sdu and ip pdu loopback: one word per cycle, far above four sdus per tti
	assign sdu_loop = (mode_q == TLE_MODE_SDU || mode_q == TLE_MODE_IP) && closed_q[sdu_rb_i];
	assign up_free = !up_valid_q || up_ready_i;
	assign sdu_ready_o = !sdu_loop || up_free;

	// sdu output register; open loops drop the stream
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			up_valid_q <= 1'b0;
			up_data_q <= '0;
			up_last_q <= 1'b0;
			up_rb_q <= '0;
			up_filter_q <= 1'b0;
		end else if (up_free) begin
			up_valid_q <= sdu_valid_i && sdu_loop;
			if (sdu_valid_i && sdu_loop) begin
				up_data_q <= sdu_data_i;
				up_last_q <= sdu_last_i;
				up_rb_q <= sdu_rb_i;
				up_filter_q <= mode_q == TLE_MODE_IP;
			end
		end
	end

	assign up_valid_o = up_valid_q;
	assign up_data_o = up_data_q;
	assign up_last_o = up_last_q;
	assign up_rb_o = up_rb_q;
	assign up_to_filter_o = up_filter_q;
endmodule // tle_loop_engine

// ===== tb/tle_loop_engine_checker.sv
// port checks for the loop engine
// assumes binding into every engine instance
`timescale 1ns/1ps
module tle_loop_engine_checker #(
	parameter int NUM_RB = 8,
	parameter int DATA_W = 32
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic close_cmd_i,
	input wire logic [1:0] close_mode_i,
	input wire logic open_cmd_i,
	input wire logic test_mode_active_i,
	input wire logic [NUM_RB-1:0] bidir_rb_i,
	input wire logic mtch_ready_i,
	input wire logic close_done_o,
	input wire logic open_done_o,
	input wire logic [NUM_RB-1:0] loop_closed_o,
	input wire logic [1:0] loop_mode_o,
	input wire logic tti_tick_i,
	input wire logic ul_valid_o,
	input wire logic [DATA_W-1:0] ul_data_o,
	input wire logic ul_ready_i,
	input wire logic sdu_valid_i,
	input wire logic [DATA_W-1:0] sdu_data_i,
	input wire logic [$clog2(NUM_RB)-1:0] sdu_rb_i,
	input wire logic sdu_ready_o,
	input wire logic up_valid_o,
	input wire logic [DATA_W-1:0] up_data_o,
	input wire logic up_to_filter_o,
	input wire logic mtch_sdu_ok_i,
	input wire logic [tle_pkg::TLE_CNT_W-1:0] sdu_count_o
);
	import tle_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// accepted commands, counted sdus and looped sdus
	sequence s_open;
		open_cmd_i && (|bidir_rb_i);
	endsequence
	sequence s_close;
		close_cmd_i && !open_cmd_i && test_mode_active_i && (close_mode_i == TLE_MODE_COUNT ? mtch_ready_i : |bidir_rb_i);
	endsequence
	sequence s_cnt;
		mtch_sdu_ok_i && !close_cmd_i && loop_mode_o == TLE_MODE_COUNT;
	endsequence
	sequence s_sdu;
		sdu_valid_i && sdu_ready_o && loop_closed_o[sdu_rb_i] && loop_mode_o[0] == loop_mode_o[1];
	endsequence
	AST_OPEN_REPLY: assert property (s_open |=> open_done_o && loop_closed_o == '0)
		else $error("open not answered");
	AST_OPEN_IGNORED: assert property (open_cmd_i && !(|bidir_rb_i) && !close_cmd_i |=> !open_done_o)
		else $error("open answered without bearer");
	AST_CLOSE_REPLY: assert property (s_close |=> close_done_o && loop_mode_o == $past(close_mode_i))
		else $error("close not answered");
	AST_COUNT_CLEAR: assert property (s_close ##0 close_mode_i == TLE_MODE_COUNT |=> sdu_count_o == TLE_CNT_RESET)
		else $error("counter not cleared");
	AST_COUNT_STEP: assert property (s_cnt |=> sdu_count_o == $past(sdu_count_o) + 32'h1)
		else $error("counter step wrong");
	AST_UL_STALL: assert property (ul_valid_o && !ul_ready_i |=> ul_valid_o && $stable(ul_data_o))
		else $error("uplink word dropped");
	AST_UL_START: assert property ($rose(ul_valid_o) |-> $past(tti_tick_i, 2))
		else $error("uplink start off tti");
	AST_SDU_LOOP: assert property (s_sdu |=> up_valid_o && up_data_o == $past(sdu_data_i) && up_to_filter_o == loop_mode_o[0])
		else $error("sdu not looped");
endmodule // tle_loop_engine_checker

bind tle_loop_engine tle_loop_engine_checker #(.NUM_RB(NUM_RB), .DATA_W(DATA_W)) chk_u (.sys_clk_i, .rst_n_i,
	.close_cmd_i, .close_mode_i, .open_cmd_i, .test_mode_active_i, .bidir_rb_i, .mtch_ready_i, .close_done_o,
	.open_done_o, .loop_closed_o, .loop_mode_o, .tti_tick_i, .ul_valid_o, .ul_data_o, .ul_ready_i, .sdu_valid_i,
	.sdu_data_i, .sdu_rb_i, .sdu_ready_o, .up_valid_o, .up_data_o, .up_to_filter_o, .mtch_sdu_ok_i, .sdu_count_o);

// ===== tb/tle_ctrl_model.sv
// controller model: loop commands, guard timer, uplink format table
// assumes one-cycle done pulses; guard shortened from the real seconds
`timescale 1ns/1ps
module tle_ctrl_model #(
	parameter int NUM_TF = 4,
	parameter int GUARD_CYC = 40
) (
	input wire logic sys_clk_i,
	input wire logic close_done_i,
	input wire logic open_done_i,
	output logic close_cmd_o,
	output logic [1:0] close_mode_o,
	output logic open_cmd_o,
	output logic [tle_pkg::TLE_TB_BITS_W-1:0] ul_tf_size_o [NUM_TF],
	output logic guard_expired_o
);
	import tle_pkg::*;
	// idle commands; formats sized for block plus crc, link unciphered
	initial begin
		close_cmd_o = 1'h0;
		open_cmd_o = 1'h0;
		close_mode_o = 2'h0;
		guard_expired_o = 1'h0;
		ul_tf_size_o = '{16'h20, 16'h10, 16'h30, 16'h18};
	end
	// one command pulse, then the guard timer until the reply
	task automatic send(input logic is_open, input logic [1:0] mode, output logic got);
		got = 1'h0;
		@(posedge sys_clk_i);
		#1;
		open_cmd_o = is_open;
		close_cmd_o = !is_open;
		close_mode_o = mode;
		@(posedge sys_clk_i);
		#1;
		open_cmd_o = 1'h0;
		close_cmd_o = 1'h0;
		for (int n = 0; n < GUARD_CYC && !got; n++) begin
			got = is_open ? open_done_i : close_done_i;
			if (!got) begin
				@(posedge sys_clk_i);
				#1;
			end
		end
		guard_expired_o = !got;
	endtask
endmodule // tle_ctrl_model

// ===== tb/tle_loop_engine_test.sv
// self-checking bench for the test loop engine
// assumes the controller model drives commands and formats
`timescale 1ns/1ps
module tle_loop_engine_test;
	import tle_pkg::*;
	localparam int DW = 8;
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, test_mode_active_i = 1'h1, mtch_ready_i = 1'h1, tti_tick_i = 1'h0;
	logic mtch_sdu_ok_i = 1'h0, dl_valid_i = 1'h0, dl_last_i = 1'h0, ul_ready_i = 1'h0, up_ready_i = 1'h1;
	logic sdu_valid_i = 1'h0, sdu_last_i = 1'h0, got, guard_expired, close_cmd_i, open_cmd_i, close_done_o;
	logic open_done_o, delay_bound_o, dl_ready_o, ul_valid_o, ul_last_o, ul_truncated_o, up_valid_o, up_last_o;
	logic up_to_filter_o, delay_fixed_o, sdu_ready_o;
	logic rb_transparent_i = 1'h1, rb_um_high_speed_i = 1'h0, cfg_change_i = 1'h0;
	logic [1:0] close_mode_i, loop_mode_o, dl_rb_i = 2'h0, sdu_rb_i = 2'h0, ul_rb_o, up_rb_o;
	logic [3:0] bidir_rb_i = 4'h0, rb_release_i = 4'h0, loop_closed_o;
	logic [DW-1:0] dl_data_i = 8'h0, sdu_data_i = 8'h0, ul_data_o, up_data_o;
	logic [TLE_TB_BITS_W-1:0] dl_tb_bits_i = 16'h0, dl_crc_bits_i = 16'h0, ul_bits_o;
	logic [TLE_TB_BITS_W-1:0] ul_tf_size_i [4];
	logic [2:0] ul_tf_idx_o;
	logic [TLE_CNT_W-1:0] sdu_count_o;
	int fails = 0;
	int checked = 0;
	// engine with segmentation property held fixed
	tle_loop_engine #(.NUM_RB(4), .DATA_W(DW), .DEPTH(64), .NUM_TF(4)) dut_u (.sys_clk_i, .rst_n_i, .close_cmd_i,
		.close_mode_i, .open_cmd_i, .test_mode_active_i, .bidir_rb_i, .rb_release_i, .mtch_ready_i,
		.close_done_o, .open_done_o, .loop_closed_o, .loop_mode_o, .rb_transparent_i,
		.rb_unsegmented_i(1'h1), .rb_um_high_speed_i, .cfg_change_i, .delay_bound_o,
		.delay_fixed_o, .tti_tick_i, .dl_valid_i, .dl_data_i, .dl_last_i, .dl_rb_i, .dl_tb_bits_i,
		.dl_crc_bits_i, .dl_ready_o, .ul_tf_size_i, .ul_valid_o, .ul_data_o, .ul_last_o, .ul_rb_o, .ul_tf_idx_o,
		.ul_bits_o, .ul_truncated_o, .ul_ready_i, .sdu_valid_i, .sdu_data_i, .sdu_last_i, .sdu_rb_i,
		.sdu_ready_o, .up_valid_o, .up_data_o, .up_last_o, .up_rb_o, .up_to_filter_o, .up_ready_i,
		.mtch_sdu_ok_i, .sdu_count_o);
	// far-side controller
	tle_ctrl_model #(.NUM_TF(4), .GUARD_CYC(40)) ss_u (.sys_clk_i, .close_done_i(close_done_o),
		.open_done_i(open_done_o), .close_cmd_o(close_cmd_i), .close_mode_o(close_mode_i), .open_cmd_o(open_cmd_i),
		.ul_tf_size_o(ul_tf_size_i), .guard_expired_o(guard_expired));
	// clock and watchdog
	always #12.5 sys_clk_i = ~sys_clk_i;
	initial begin
		#125000;
		fails++;
		final_report();
	end
	// compare and verdict
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
		end
	endtask
	// commands without bearers or channel are refused
	task automatic t_refuse();
		ss_u.send(1'h1, TLE_MODE_SDU, got);
		check("open reply", {got, guard_expired}, 2'h1);
		ss_u.send(1'h0, TLE_MODE_TB, got);
		check("close reply", got, 0);
		bidir_rb_i = 4'h5;
		mtch_ready_i = 1'h0;
		ss_u.send(1'h0, TLE_MODE_COUNT, got);
		check("count close", got, 0);
		mtch_ready_i = 1'h1;
	endtask
	// every mode code, then open twice
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			ss_u.send(1'h0, 2'(m), got);
			check("mode", {got, loop_mode_o}, {1'h1, 2'(m)});
			if (m != 3) check("bound", delay_bound_o, m != 2);
			if (m != 2) check("closed", loop_closed_o, bidir_rb_i);
		end
		ss_u.send(1'h1, TLE_MODE_SDU, got);
		check("open", {got, loop_closed_o}, 5'h10);
		ss_u.send(1'h1, TLE_MODE_SDU, got);
		check("reopen", got, 1);
	endtask
	// counting and clearing
	task automatic t_count();
		ss_u.send(1'h0, TLE_MODE_COUNT, got);
		mtch_sdu_ok_i = 1'h1;
		cyc(5);
		mtch_sdu_ok_i = 1'h0;
		cyc(1);
		check("count", sdu_count_o, 5);
		ss_u.send(1'h0, TLE_MODE_COUNT, got);
		check("cleared", sdu_count_o, 0);
	endtask
	// one four-word sdu, sdu and ip modes
	task automatic t_sdu();
		for (int k = 0; k < 2; k++) begin
			ss_u.send(1'h0, k ? TLE_MODE_IP : TLE_MODE_SDU, got);
			sdu_rb_i = 2'h2;
			sdu_valid_i = 1'h1;
			for (int w = 0; w < 4; w++) begin
				sdu_data_i = 8'(8'h40 + w);
				sdu_last_i = w == 3;
				cyc(1);
				check("up", {up_valid_o, up_to_filter_o, up_last_o, up_data_o}, {1'h1, k[0], w == 3, sdu_data_i});
				check("up rb", {up_rb_o, sdu_ready_o}, {2'h2, 1'h1});
			end
			sdu_valid_i = 1'h0;
			sdu_last_i = 1'h0;
		end
		// uplink stalled: the looped word holds and the stream is held off
		cyc(1);
		up_ready_i = 1'h0;
		sdu_valid_i = 1'h1;
		sdu_data_i = 8'h55;
		sdu_last_i = 1'h1;
		cyc(2);
		check("up stall", {sdu_ready_o, up_valid_o, up_data_o}, {1'h0, 1'h1, 8'h55});
		sdu_valid_i = 1'h0;
		sdu_last_i = 1'h0;
		up_ready_i = 1'h1;
		cyc(1);
	endtask
	// configuration change, bearer release, bound exceptions, test mode off
	task automatic t_bearer();
		check("fixed", delay_fixed_o, 1);
		cfg_change_i = 1'h1;
		cyc(1);
		cfg_change_i = 1'h0;
		check("cfg change", delay_fixed_o, 0);
		cyc(1);
		check("refixed", delay_fixed_o, 1);
		rb_release_i = 4'h1;
		cyc(1);
		rb_release_i = 4'h0;
		check("release", {loop_closed_o, delay_fixed_o}, 5'h8);
		ss_u.send(1'h0, TLE_MODE_SDU, got);
		rb_um_high_speed_i = 1'h1;
		cyc(1);
		check("um bound", delay_bound_o, 0);
		rb_um_high_speed_i = 1'h0;
		rb_transparent_i = 1'h0;
		cyc(1);
		check("tm bound", delay_bound_o, 0);
		rb_transparent_i = 1'h1;
		test_mode_active_i = 1'h0;
		ss_u.send(1'h0, TLE_MODE_SDU, got);
		check("no test mode", {got, loop_closed_o}, 5'h0);
		test_mode_active_i = 1'h1;
	endtask
	// one block through hold, tti start, stall and send
	task automatic t_block(input int tbb, input int crc, input int idx, input int bits, input logic trunc);
		int d;
		dl_rb_i = 2'h2;
		dl_valid_i = 1'h1;
		dl_tb_bits_i = 16'(tbb);
		dl_crc_bits_i = 16'(crc);
		for (int w = 0; w < (tbb + crc) / DW; w++) begin
			dl_data_i = 8'(8'hA0 + w);
			dl_last_i = w == (tbb + crc) / DW - 1;
			cyc(1);
		end
		dl_valid_i = 1'h0;
		dl_last_i = 1'h0;
		cyc(3);
		check("hold", {dl_ready_o, ul_truncated_o, ul_tf_idx_o, ul_bits_o}, {1'h0, trunc, 3'(idx), 16'(bits)});
		check("ul rb", ul_rb_o, 2'h2);
		tti_tick_i = 1'h1;
		cyc(1);
		tti_tick_i = 1'h0;
		for (d = 1; d < 20 && ul_valid_o !== 1'h1; d++) cyc(1);
		check("delay", d, 2);
		cyc(2);
		ul_ready_i = 1'h1;
		for (int w = 0; w < bits / DW; w++) begin
			check("ul", {ul_valid_o, ul_last_o, ul_data_o}, {1'h1, w == bits / DW - 1, 8'(8'hA0 + w)});
			cyc(1);
		end
		ul_ready_i = 1'h0;
		check("ul idle", ul_valid_o, 0);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1'h1;
		check("reset", {loop_closed_o, loop_mode_o, sdu_count_o}, 38'h0);
		t_refuse();
		t_modes();
		t_count();
		t_sdu();
		ss_u.send(1'h0, TLE_MODE_TB, got);
		t_block(16, 8, 3, 24, 1'h0);
		t_block(48, 8, 2, 48, 1'h1);
		t_bearer();
		final_report();
	end
endmodule // tle_loop_engine_test
